// ### rtl/tmc_map.svh
// register map, field layout, reset values and timing counts of the timer
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
// Notes on behaviour
// - interval mode counts one per source tick while start field is 01
// - interval mode match raises interrupt, clears counter, keeps counting
// - auto-capture copies live count to capture register each source tick while mode field is 00
// - trigger mode holds counter until trigger edge, then counts source ticks
// - trigger mode match clears and halts counter and raises interrupt
// - with trigger-stop set, opposite edge before match clears and halts silently
// - halted trigger timer restarts from zero at next trigger edge
// - trigger-stop clear ignores opposite edge and repeated triggers while counting
// - pin filter rejects pulses up to 4/fc, passes pulses of 12/fc or more
// - low-clock modes bypass filter; source holds levels one machine cycle
// - event mode counts selected pin edges instead of the internal clock
// - event mode checks match at opposite edge, interrupts, clears, continues
// - window mode counts source ticks gated by pin level per polarity
// - window mode match raises interrupt and clears counter
// - mode field 00 selects timer/trigger/event, 01 selects window
// - start field: 00 stop and clear, 01 command, 10 rising, 11 falling
// - new limit takes effect at first source tick after upper half write
// - entering stop power mode forces start field to 00
`define TMC_OFS_CTRL 6'h00
`define TMC_OFS_LIMIT_LO 6'h04
`define TMC_OFS_LIMIT_HI 6'h08
`define TMC_OFS_CAPTURE 6'h0c
`define TMC_OFS_COUNT 6'h10
`define TMC_OFS_STATUS 6'h14
`define TMC_OFS_PRESC 6'h18
`define TMC_CTRL_MODE_LSB 0
`define TMC_CTRL_CLK_LSB 2
`define TMC_CTRL_START_LSB 4
`define TMC_CTRL_TSTOP_BIT 6
`define TMC_CTRL_ACAP_BIT 7
`define TMC_CTRL_RST 8'h00
`define TMC_LIMIT_RST 16'hffff
`define TMC_CAPTURE_RST 16'hffff
`define TMC_PRESC_RST 1'b0
`define TMC_FC_MHZ 200
`define TMC_REJECT_FC 4
`define TMC_ACCEPT_FC 12
`define TMC_DIV_SLOW 11
`define TMC_DIV_MID 7
`define TMC_DIV_FAST 3
`define TMC_DIV_LOWCLK 3
`endif

// ### rtl/tmc_pkg.sv
// types shared by the timer files
package tmc_pkg;
  typedef enum logic [1:0]
  {
    TMC_MODE_TIMER = 2'b00,
    TMC_MODE_WINDOW = 2'b01,
    TMC_MODE_PULSE = 2'b10,
    TMC_MODE_PPG = 2'b11
  } tmc_mode_t;
  typedef enum logic [1:0]
  {
    TMC_START_STOP = 2'b00,
    TMC_START_CMD = 2'b01,
    TMC_START_RISE = 2'b10,
    TMC_START_FALL = 2'b11
  } tmc_start_t;
  typedef enum logic [1:0]
  {
    TMC_ST_IDLE = 2'b00,
    TMC_ST_RUN = 2'b01,
    TMC_ST_HALT = 2'b10
  } tmc_state_t;
endpackage

// ### rtl/tmc_pin_filter.sv
// noise filter and edge detector for the count input pin
`timescale 1ns/1ps
module tmc_pin_filter
  import tmc_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_in,
  input wire logic bypass,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  initial
  begin
    if (STABLE_CYCLES < 2 || STABLE_CYCLES > 255)
      $error("tmc_pin_filter: STABLE_CYCLES out of range");
  end

  logic pin_ff;
  logic [7:0] run_ff;
  logic level_ff;
  logic prev_ff;
  logic nxt_level;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pin_ff <= 1'b0;
    else
      pin_ff <= pin_in;
  end

  // level must hold a whole window before it is believed
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      run_ff <= 8'h00;
    else if (pin_ff == level_ff)
      run_ff <= 8'h00;
    else
      run_ff <= run_ff + 8'h01;
  end

  always_comb
  begin
    nxt_level = level_ff;
    if (bypass)
      nxt_level = pin_ff;
    else if (pin_ff != level_ff && run_ff == 8'(STABLE_CYCLES - 1))
      nxt_level = pin_ff;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      level_ff <= nxt_level;
      prev_ff <= level_ff;
    end
  end

  assign level_out = level_ff;
  assign rise_out = level_ff & ~prev_ff;
  assign fall_out = ~level_ff & prev_ff;
endmodule

// ### rtl/tmc_timer.sv
// multimode 16-bit timer counter with an axi4-lite register slave
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned FILTER_CYCLES = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic count_input_pin,
  input wire logic low_clock_run_mode,
  input wire logic low_clock_sleep_mode,
  input wire logic stop_mode_entry,
  output logic match_interrupt
);
  initial
  begin
    if (CNT_W != 16)
      $error("tmc_timer: CNT_W must be 16");
    if (FILTER_CYCLES <= `TMC_REJECT_FC || FILTER_CYCLES >= `TMC_ACCEPT_FC)
      $error("tmc_timer: FILTER_CYCLES must lie in (4,12)");
  end

  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  logic [7:0] ctrl_ff;
  logic [15:0] limit_ff;
  logic [15:0] limit_stage_ff;
  logic limit_pend_ff;
  logic [15:0] capture_ff;
  logic [15:0] count_ff;
  logic prescaler_tap_select_ff;
  logic match_ff;
  logic [10:0] div_ff;
  logic [10:0] div_prev_ff;
  logic tick;
  tmc_state_t state_ff;
  tmc_state_t nxt_state;
  logic [15:0] nxt_count;
  logic hit;

  logic low_clk;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  tmc_mode_t mode_select_field;
  tmc_start_t start_control_field;
  logic [1:0] source_clock_select;
  logic trigger_stop_select;
  logic auto_capture_enable;
  logic trig_edge;
  logic opp_edge;
  logic gate_level;
  logic event_mode;
  logic src_tick;

  // axi write and read paths
  logic aw_ff;
  logic w_ff;
  logic [5:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic wr_hit;

  assign mode_select_field = tmc_mode_t'(ctrl_ff[`TMC_CTRL_MODE_LSB +: 2]);
  assign source_clock_select = ctrl_ff[`TMC_CTRL_CLK_LSB +: 2];
  assign start_control_field =
    tmc_start_t'(ctrl_ff[`TMC_CTRL_START_LSB +: 2]);
  assign trigger_stop_select = ctrl_ff[`TMC_CTRL_TSTOP_BIT];
  assign auto_capture_enable = ctrl_ff[`TMC_CTRL_ACAP_BIT];
  assign low_clk = low_clock_run_mode | low_clock_sleep_mode;

  tmc_pin_filter #(
    .STABLE_CYCLES(FILTER_CYCLES)
  ) u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(count_input_pin),
    .bypass(low_clk),
    .level_out(pin_level),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // falling-edge code selects the opposite polarity
  assign trig_edge = (start_control_field == TMC_START_FALL) ? pin_fall
                                                             : pin_rise;
  assign opp_edge = (start_control_field == TMC_START_FALL) ? pin_rise
                                                            : pin_fall;
  assign gate_level = (start_control_field == TMC_START_FALL) ? ~pin_level
                                                              : pin_level;

  // source select 11 in mode 00 with start code 10 or 11 turns the pin edges into the count clock
  assign event_mode = (mode_select_field == TMC_MODE_TIMER)
    && (source_clock_select == 2'b11)
    && (start_control_field == TMC_START_RISE
        || start_control_field == TMC_START_FALL);
  assign src_tick = event_mode ? trig_edge : tick;

  // free-running prescaler; low-clock modes use the TMC_DIV_LOWCLK tap only
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff <= 11'h000;
      div_prev_ff <= 11'h000;
    end
    else
    begin
      div_ff <= div_ff + 11'h001;
      div_prev_ff <= div_ff;
    end
  end

  always_comb
  begin
    tick = 1'b0;
    if (low_clk)
      tick = div_ff[`TMC_DIV_LOWCLK - 1] & ~div_prev_ff[`TMC_DIV_LOWCLK - 1];
    else
      case (source_clock_select)
        2'b00:
          tick = prescaler_tap_select_ff
            ? (div_ff[`TMC_DIV_LOWCLK - 1] & ~div_prev_ff[`TMC_DIV_LOWCLK - 1])
            : (div_ff[`TMC_DIV_SLOW - 1] & ~div_prev_ff[`TMC_DIV_SLOW - 1]);
        2'b01:
          tick = div_ff[`TMC_DIV_MID - 1] & ~div_prev_ff[`TMC_DIV_MID - 1];
        2'b10:
          tick = div_ff[`TMC_DIV_FAST - 1] & ~div_prev_ff[`TMC_DIV_FAST - 1];
        default:
          tick = 1'b0;
      endcase
  end

  assign hit = (count_ff == limit_ff);

  // counting state machine for interval, trigger, event and window modes; mode codes 10 and 11 stay idle
  always_comb
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    if (start_control_field == TMC_START_STOP)
    begin
      nxt_state = TMC_ST_IDLE;
      nxt_count = 16'h0000;
    end
    else if (mode_select_field == TMC_MODE_WINDOW)
    begin
      nxt_state = TMC_ST_RUN;
      if (tick && gate_level && start_control_field != TMC_START_CMD)
        nxt_count = count_ff + 16'h0001;
      if (hit)
        nxt_count = 16'h0000;
    end
    else if (event_mode)
    begin
      nxt_state = TMC_ST_RUN;
      if (opp_edge && hit)
        nxt_count = 16'h0000;
      else if (trig_edge)
        nxt_count = count_ff + 16'h0001;
    end
    else if (mode_select_field == TMC_MODE_TIMER)
    begin
      case (start_control_field)
        TMC_START_CMD:
        begin
          nxt_state = TMC_ST_RUN;
          if (hit)
            nxt_count = 16'h0000;
          else if (tick)
            nxt_count = count_ff + 16'h0001;
        end
        default:
        begin
          if (state_ff == TMC_ST_RUN)
          begin
            if (hit)
            begin
              nxt_state = TMC_ST_HALT;
              nxt_count = 16'h0000;
            end
            else if (trigger_stop_select && opp_edge)
            begin
              nxt_state = TMC_ST_HALT;
              nxt_count = 16'h0000;
            end
            else if (tick)
              nxt_count = count_ff + 16'h0001;
          end
          else if (trig_edge)
          begin
            nxt_state = TMC_ST_RUN;
            nxt_count = 16'h0000;
          end
        end
      endcase
    end
    else
      nxt_state = TMC_ST_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= TMC_ST_IDLE;
      count_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  // registered match flag; decoded from the live compare each cycle, not from its edge
  logic nxt_match;
  always_comb
  begin
    nxt_match = 1'b0;
    if (start_control_field != TMC_START_STOP && hit)
    begin
      if (mode_select_field == TMC_MODE_WINDOW)
        nxt_match = 1'b1;
      else if (event_mode)
        nxt_match = opp_edge;
      else if (mode_select_field == TMC_MODE_TIMER)
        nxt_match = (start_control_field == TMC_START_CMD)
          || (state_ff == TMC_ST_RUN);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      match_ff <= 1'b0;
    else
      match_ff <= nxt_match;
  end
  assign match_interrupt = match_ff;

  // with auto-capture set in mode 00, capture follows the live count on each source tick
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      capture_ff <= `TMC_CAPTURE_RST;
    else if (auto_capture_enable && src_tick
             && mode_select_field == TMC_MODE_TIMER
             && start_control_field != TMC_START_STOP)
      capture_ff <= count_ff;
  end

  // limit staging: upper half write arms, next source tick loads
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      limit_ff <= `TMC_LIMIT_RST;
      limit_pend_ff <= 1'b0;
    end
    else if (wr_go && wr_hit && awaddr_ff == `TMC_OFS_LIMIT_HI)
      limit_pend_ff <= 1'b1;
    else if (limit_pend_ff && src_tick)
    begin
      limit_ff <= limit_stage_ff;
      limit_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      limit_stage_ff <= `TMC_LIMIT_RST;
    else if (wr_go && awaddr_ff == `TMC_OFS_LIMIT_LO && wstrb_ff[0])
      limit_stage_ff[7:0] <= wdata_ff[7:0];
    else if (wr_go && awaddr_ff == `TMC_OFS_LIMIT_HI && wstrb_ff[0])
      limit_stage_ff[15:8] <= wdata_ff[7:0];
  end

  // control register; stop mode entry wins over a software write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= `TMC_CTRL_RST;
    else if (stop_mode_entry)
      ctrl_ff[`TMC_CTRL_START_LSB +: 2] <= TMC_START_STOP;
    else if (wr_go && awaddr_ff == `TMC_OFS_CTRL && wstrb_ff[0])
      ctrl_ff <= wdata_ff[7:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prescaler_tap_select_ff <= `TMC_PRESC_RST;
    else if (wr_go && awaddr_ff == `TMC_OFS_PRESC && wstrb_ff[0])
      prescaler_tap_select_ff <= wdata_ff[0];
  end

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_ff & ~bvalid_ff;
  assign wr_go = aw_ff & w_ff & ~bvalid_ff;
  assign wr_hit = (awaddr_ff == `TMC_OFS_CTRL)
    || (awaddr_ff == `TMC_OFS_LIMIT_LO) || (awaddr_ff == `TMC_OFS_LIMIT_HI)
    || (awaddr_ff == `TMC_OFS_PRESC);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 6'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (wr_go)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OK;
    end
    else if (wr_go)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OK : RESP_ERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // axi4-lite read: one cycle to answer, held until rready
  assign s_axi_arready = ~rvalid_ff;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OK;
    end
    else if (s_axi_arvalid && ~rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= RESP_OK;
      case ({s_axi_araddr[5:2], 2'b00})
        `TMC_OFS_CTRL: rdata_ff <= {24'h000000, ctrl_ff};
        `TMC_OFS_LIMIT_LO: rdata_ff <= {24'h000000, limit_ff[7:0]};
        `TMC_OFS_LIMIT_HI: rdata_ff <= {24'h000000, limit_ff[15:8]};
        `TMC_OFS_CAPTURE: rdata_ff <= {16'h0000, capture_ff};
        `TMC_OFS_COUNT: rdata_ff <= {16'h0000, count_ff};
        `TMC_OFS_STATUS: rdata_ff <= {28'h0000000, limit_pend_ff,
                                      pin_level, state_ff};
        `TMC_OFS_PRESC: rdata_ff <= {31'h00000000, prescaler_tap_select_ff};
        default:
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule

// ### testbench/tmc_timer_monitor.sv
// assertion checker on the timer's bus and interrupt ports
`timescale 1ns/1ps
module tmc_timer_monitor
  import tmc_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned FILTER_CYCLES = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic stop_mode_entry,
  input wire logic match_interrupt
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence bad_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[5:2] > 4'h6);
  endsequence
  chk_irq_one_pulse: assert property (
    match_interrupt |=> !match_interrupt) else $error("irq wider");
  // margin of three cycles covers a match already in flight
  chk_irq_after_stop: assert property (
    stop_mode_entry ##3 1'b1 |-> !match_interrupt [*8])
    else $error("irq after stop");
  chk_reset_quiet: assert property (
    !$past(rst_n) |-> !match_interrupt && !s_axi_bvalid && !s_axi_rvalid)
    else $error("output after reset");
  chk_wr_answer: assert property (
    wr_taken |-> ##2 s_axi_bvalid) else $error("no write response");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  chk_aw_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  chk_rd_slverr: assert property (
    bad_read |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  chk_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
endmodule

bind tmc_timer tmc_timer_monitor #(.CNT_W(CNT_W),
  .FILTER_CYCLES(FILTER_CYCLES)) u_mon (.clk_sys, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .stop_mode_entry, .match_interrupt);

// ### testbench/tmc_pulse_src.sv
// behavioural pulse source on the count input pin
`timescale 1ns/1ps
module tmc_pulse_src
(
  input wire logic clk_sys,
  output logic pin
);
  initial pin = 1'b0;
  // levels change just after an edge and last whole cycles
  task automatic drive(input logic lvl, input int n);
    pin <= lvl;
    repeat (n) @(posedge clk_sys);
  endtask
endmodule

// ### testbench/timer_counter_multimode_16bit_tb.sv
// self-checking bench of the multimode timer
`timescale 1ns/1ps
`include "tmc_map.svh"
module timer_counter_multimode_16bit_tb;
  import tmc_pkg::*;
  localparam logic [5:0] A_CTL = `TMC_OFS_CTRL;
  localparam logic [5:0] A_LO = `TMC_OFS_LIMIT_LO;
  localparam logic [5:0] A_HI = `TMC_OFS_LIMIT_HI;
  localparam logic [5:0] A_CNT = `TMC_OFS_COUNT;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic low_clock_run_mode = 1'b0, low_clock_sleep_mode = 1'b0;
  logic stop_mode_entry = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, match_interrupt, count_input_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_errors = 0, total_checks = 0, cyc = 0, irq_cnt = 0, irq_at = 0;
  always #2.5 clk_sys = ~clk_sys;
  tmc_pulse_src src (.clk_sys(clk_sys), .pin(count_input_pin));
  tmc_timer dut (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .count_input_pin, .low_clock_run_mode,
    .low_clock_sleep_mode, .stop_mode_entry, .match_interrupt);
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // the whole run needs about 3700 cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (match_interrupt === 1'b1)
    begin
      irq_cnt <= irq_cnt + 1;
      irq_at <= cyc;
    end
    if (cyc == 20000)
    begin
      n_errors++;
      test_done;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wv(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("bresp", r, 2'b00);
  endtask
  task automatic rv(input logic [5:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
    check("rresp", r, 2'b00);
  endtask
  // stop first: mode bits may only change while stopped
  task automatic cfg(input logic [7:0] v);
    wv(A_CTL, 32'h0);
    wv(A_CTL, {24'h0, v});
  endtask
  task automatic lim(input logic [15:0] v);
    wv(A_LO, {24'h0, v[7:0]});
    wv(A_HI, {24'h0, v[15:8]});
  endtask
  task automatic period(output int p);
    int c, t;
    c = irq_cnt;
    wait (irq_cnt == c + 1);
    t = irq_at;
    wait (irq_cnt == c + 2);
    p = irq_at - t;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rv(A_CTL, d);
    check("ctrl reset", d, {24'h0, `TMC_CTRL_RST});
    rv(`TMC_OFS_CAPTURE, d);
    check("capture reset", d, {16'h0, `TMC_CAPTURE_RST});
    rd(6'h1c, d, r);
    check("unmapped rresp", r, 2'b10);
    check("unmapped rdata", d, 32'h0);
    wr(6'h1c, 32'h5a, r);
    check("unmapped bresp", r, 2'b10);
  endtask
  task automatic t_intv;
    int p1, p2, c;
    logic [31:0] d;
    lim(16'd5);
    cfg(8'h18);
    period(p1);
    check("period", p1 >= 40 && p1 <= 48, 1'b1);
    wv(A_LO, 32'h2);
    period(p2);
    check("low half only", p2, p1);
    c = irq_cnt;
    wait (irq_cnt != c);
    wv(A_HI, 32'h0);
    period(p2);
    check("new limit", p2 >= 16 && p2 <= 24, 1'b1);
    cfg(8'h98);
    repeat (20) @(posedge clk_sys);
    rv(`TMC_OFS_CAPTURE, d);
    check("capture", d <= 2, 1'b1);
    rv(A_CNT, d);
    check("count", d <= 2, 1'b1);
  endtask
  task automatic t_stop;
    int c;
    logic [31:0] d;
    wv(A_CTL, 32'h0);
    rv(A_CNT, d);
    check("cleared", d, 32'h0);
    wv(A_CTL, 32'h18);
    repeat (10) @(posedge clk_sys);
    stop_mode_entry <= 1'b1;
    @(posedge clk_sys);
    stop_mode_entry <= 1'b0;
    rv(A_CTL, d);
    check("start forced", d[5:4], 2'b00);
    c = irq_cnt;
    repeat (100) @(posedge clk_sys);
    check("stopped irq", irq_cnt - c, 0);
  endtask
  task automatic t_trig;
    int c, t0;
    logic [31:0] d;
    lim(16'd20);
    for (int s = 2; s < 4; s++)
    begin
      src.drive(s == 3, 30);
      cfg({2'b01, s[1:0], 4'b1000});
      c = irq_cnt;
      repeat (100) @(posedge clk_sys);
      rv(A_CNT, d);
      check("held", d, 32'h0);
      src.drive(s == 2, 48);
      src.drive(s == 3, 30);
      rv(A_CNT, d);
      check("abort count", d, 32'h0);
      check("abort irq", irq_cnt - c, 0);
      src.drive(s == 2, 250);
      check("match irq", irq_cnt - c, 1);
      rv(A_CNT, d);
      check("halted", d, 32'h0);
      src.drive(s == 3, 30);
      src.drive(s == 2, 250);
      check("restart irq", irq_cnt - c, 2);
    end
    src.drive(1'b0, 30);
    cfg(8'h28);
    c = irq_cnt;
    t0 = cyc;
    src.drive(1'b1, 48);
    src.drive(1'b0, 30);
    src.drive(1'b1, 20);
    src.drive(1'b0, 200);
    check("no stop irq", irq_cnt - c, 1);
    check("irq time", irq_at - t0 >= 150 && irq_at - t0 <= 200, 1'b1);
  endtask
  task automatic t_filt;
    int c;
    lim(16'd3);
    cfg(8'h28);
    for (int m = 0; m < 3; m++)
    begin
      low_clock_run_mode <= (m == 1);
      low_clock_sleep_mode <= (m == 2);
      c = irq_cnt;
      src.drive(1'b1, 4);
      src.drive(1'b0, 100);
      check("short pulse", irq_cnt - c, m != 0);
      src.drive(1'b1, 12);
      src.drive(1'b0, 100);
      check("long pulse", irq_cnt - c, 1 + (m != 0));
    end
    low_clock_sleep_mode <= 1'b0;
  endtask
  task automatic t_win;
    int c;
    logic [31:0] d;
    lim(16'd4);
    for (int p = 0; p < 2; p++)
    begin
      src.drive(p[0], 30);
      cfg({3'b001, p[0], 4'b1001});
      c = irq_cnt;
      src.drive(p[0], 150);
      rv(A_CNT, d);
      check("gated count", d, 32'h0);
      src.drive(!p[0], 100);
      check("window irq", irq_cnt - c >= 2, 1'b1);
    end
  endtask
  // pin edges clock the counter; match waits for the opposite edge
  task automatic t_evt;
    int c;
    logic [31:0] d;
    lim(16'd3);
    cfg(8'h2c);
    c = irq_cnt;
    for (int k = 0; k < 3; k++)
    begin
      src.drive(1'b1, 16);
      if (k == 2)
        check("irq before fall", irq_cnt - c, 0);
      src.drive(1'b0, 16);
      if (k == 1)
      begin
        rv(A_CNT, d);
        check("event count", d, 32'h2);
      end
    end
    check("event irq", irq_cnt - c, 1);
    rv(A_CNT, d);
    check("event clear", d, 32'h0);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs;
    t_intv;
    t_stop;
    t_trig;
    t_filt;
    t_win;
    t_evt;
    test_done;
  end
endmodule
